// *** src/dadc_regs.svh ***
`ifndef DADC_REGS_SVH
`define DADC_REGS_SVH

// Register byte offsets, low address bits only
`define DADC_CTRL_OFFSET    4'h0
`define DADC_STATUS_OFFSET  4'h4
`define DADC_COEF_OFFSET    4'h8
`define DADC_RESULT_OFFSET  4'hC

// Control word: bit 0 bus select, 1 coding, 2 hold, 3 sleep, 4 gain, 5 trigger
`define DADC_CTRL_WIDTH     6
`define DADC_CTRL_RESET     6'h01

// Status word layout
`define DADC_STATUS_BUSY    0
`define DADC_STATUS_PWR_LSB 1
`define DADC_STATUS_PWR_MSB 3

// Coefficient and result words: channel one low, channel two from bit 16
`define DADC_WORD_Q_LSB     16
`define DADC_WORD_Q_MSB     25

// Correction sequence timing in clock cycles
`define DADC_CAL_CYCLES     34
`define DADC_CAL_LAST       6'h21
`define DADC_CAL_FIRST_ACC  6'h02
`define DADC_CAL_LAST_ACC   6'h21

`endif

// *** src/dadc_pkg.sv ***
package dadc_pkg;

  typedef enum logic [2:0]
  {
    DADC_PWR_NORMAL  = 3'b001,
    DADC_PWR_STANDBY = 3'b010,
    DADC_PWR_SLEEP   = 3'b100
  } dadc_power_type;

  typedef enum logic [1:0]
  {
    DADC_CAL_IDLE = 2'b01,
    DADC_CAL_RUN  = 2'b10
  } dadc_cal_type;

  typedef struct packed
  {
    logic trigger;
    logic gain_high;
    logic sleep_request;
    logic low_power_hold;
    logic output_coding_select;
    logic bus_select;
  } dadc_ctrl_type;

  typedef struct packed
  {
    logic [9:0] i;
    logic [9:0] q;
  } dadc_pair_type;

endpackage

// *** src/dadc_ctrl.sv ***
`timescale 1ns/1ns
`include "dadc_regs.svh"
// Notes on behaviour
// R1 - Both channels are sampled together on the falling clock edge.
// R2 - Bus select high: each channel drives its own output bus.
// R3 - Bus select low: both channels share bus one; bus two is driven low.
// R4 - A rising offset trigger starts one correction sequence per channel.
// R5 - A sequence lasts 34 cycles and averages 32 conversions into a coefficient.
// R6 - The stored coefficient is subtracted from every later result of its channel.
// R7 - Both coefficients are zero after reset.
// R8 - Software triggers correction once after power-up, again only after power loss.
// R9 - Software holds inputs at zero and allows 35 cycles for the sequence.
// R10 - Coding select low gives offset binary, high gives two's complement.
// R11 - Conversion runs only with hold and sleep low; hold alone means standby.
// R12 - In standby the outputs keep the last result.
// R13 - Sleep request high stops conversion in the sleep state.
// R14 - Hold and sleep together behave as sleep.
// R15 - In sleep the outputs keep the last result.
// R16 - Gain low selects span equal to reference, high twice the reference.
// R17 - Software supplies a clean clock of 1 to 30 MHz, nominally 20 MHz.
// R18 - Parallel mode latency is 2.5 cycles from sample to bus.
// R19 - Multiplexed mode latency is 2.5 cycles for channel one, 3.0 for two.
// R20 - Shared bus shows channel one after the rise and channel two after the fall.
// R21 - Trigger edge is detected on the clock; edges during a sequence are ignored.
module dadc_ctrl
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic [9:0]  conv_i_raw,
  input  wire logic [9:0]  conv_q_raw,
  output logic [9:0]       bus_a_data,
  output logic [9:0]       bus_b_data,
  output logic             analog_gain_high,
  output logic             analog_standby,
  output logic             analog_sleep
);

  typedef struct packed
  {
    dadc_pkg::dadc_ctrl_type  ctrl;
    logic                     trig_prev;
    dadc_pkg::dadc_power_type power;
    dadc_pkg::dadc_cal_type   cal;
    logic [5:0]               cal_cnt;
    logic [14:0]              acc_i;
    logic [14:0]              acc_q;
    logic [9:0]               coef_i;
    logic [9:0]               coef_q;
    dadc_pkg::dadc_pair_type  s1;
    dadc_pkg::dadc_pair_type  s2;
    dadc_pkg::dadc_pair_type  out;
    logic                     wr_pend;
    logic [3:0]               wr_addr;
    logic [31:0]              rdata;
  } dadc_state_type;

  typedef struct packed
  {
    dadc_pkg::dadc_pair_type samp;
    logic [9:0]              mux_q;
  } dadc_fall_type;

  dadc_state_type st_reg;
  dadc_state_type st_next;
  dadc_fall_type  fl_reg;
  dadc_fall_type  fl_next;
  logic           converting;
  logic           trig_rise;
  logic           addr_valid;

  // Raw code to signed, minus coefficient, clamped to ten bits
  function automatic logic [9:0] dadc_correct(input logic [9:0] raw, input logic [9:0] coef);
    logic [11:0] d;
    d = {{2{~raw[9]}}, ~raw[9], raw[8:0]} - {{2{coef[9]}}, coef};
    if (!d[11] && d[10:9] != 2'b00)
      dadc_correct = 10'h1FF;
    else if (d[11] && d[10:9] != 2'b11)
      dadc_correct = 10'h200;
    else
      dadc_correct = d[9:0];
  endfunction

  function automatic logic [9:0] dadc_format(input logic [9:0] v, input logic twos);
    dadc_format = twos ? v : {~v[9], v[8:0]};
  endfunction

  function automatic logic [14:0] dadc_sext(input logic [9:0] raw);
    dadc_sext = {{5{~raw[9]}}, ~raw[9], raw[8:0]};
  endfunction

  assign converting = (st_reg.power == dadc_pkg::DADC_PWR_NORMAL);          // [R11]
  assign trig_rise  = st_reg.ctrl.trigger && !st_reg.trig_prev;             // [R21]
  assign addr_valid = hsel && hready && htrans[1];

  always_comb
  begin
    st_next = st_reg;
    st_next.trig_prev = st_reg.ctrl.trigger;
    // Bus write lands in the data phase; zero wait states
    if (st_reg.wr_pend && st_reg.wr_addr == `DADC_CTRL_OFFSET)
      st_next.ctrl = dadc_pkg::dadc_ctrl_type'(hwdata[`DADC_CTRL_WIDTH-1:0]);
    st_next.wr_pend = addr_valid && hwrite;
    st_next.wr_addr = haddr[3:0];
    if (addr_valid && !hwrite)
    begin
      st_next.rdata = 32'h0000_0000;
      case (haddr[3:0])
        `DADC_CTRL_OFFSET:
          st_next.rdata[`DADC_CTRL_WIDTH-1:0] = st_reg.ctrl;
        `DADC_STATUS_OFFSET:
        begin
          st_next.rdata[`DADC_STATUS_BUSY] = (st_reg.cal == dadc_pkg::DADC_CAL_RUN);
          st_next.rdata[`DADC_STATUS_PWR_MSB:`DADC_STATUS_PWR_LSB] = st_reg.power;
        end
        `DADC_COEF_OFFSET:
        begin
          st_next.rdata[9:0] = st_reg.coef_i;
          st_next.rdata[`DADC_WORD_Q_MSB:`DADC_WORD_Q_LSB] = st_reg.coef_q;
        end
        `DADC_RESULT_OFFSET:
        begin
          st_next.rdata[9:0] = st_reg.out.i;
          st_next.rdata[`DADC_WORD_Q_MSB:`DADC_WORD_Q_LSB] = st_reg.out.q;
        end
        default:
          st_next.rdata = 32'h0000_0000;
      endcase
    end
    // Sleep outranks standby
    if (st_reg.ctrl.sleep_request)                                          // [R13] [R14]
      st_next.power = dadc_pkg::DADC_PWR_SLEEP;
    else if (st_reg.ctrl.low_power_hold)                                    // [R11]
      st_next.power = dadc_pkg::DADC_PWR_STANDBY;
    else
      st_next.power = dadc_pkg::DADC_PWR_NORMAL;
    case (st_reg.cal)
      dadc_pkg::DADC_CAL_IDLE:
      begin
        // Edges seen while running are dropped, not queued
        if (trig_rise)                                                      // [R4] [R21]
        begin
          st_next.cal     = dadc_pkg::DADC_CAL_RUN;
          st_next.cal_cnt = 6'h00;
          st_next.acc_i   = 15'h0000;
          st_next.acc_q   = 15'h0000;
        end
      end
      dadc_pkg::DADC_CAL_RUN:
      begin
        // Count pauses while not converting; the first sample added after a pause is captured on the first falling edge after conversion resumes
        if (converting)
        begin
          if (st_reg.cal_cnt >= `DADC_CAL_FIRST_ACC && st_reg.cal_cnt <= `DADC_CAL_LAST_ACC)
          begin
            st_next.acc_i = st_reg.acc_i + dadc_sext(fl_reg.samp.i);        // [R5]
            st_next.acc_q = st_reg.acc_q + dadc_sext(fl_reg.samp.q);
          end
          if (st_reg.cal_cnt == `DADC_CAL_LAST)
          begin
            st_next.cal    = dadc_pkg::DADC_CAL_IDLE;
            st_next.coef_i = st_next.acc_i[14:5];                           // [R5]
            st_next.coef_q = st_next.acc_q[14:5];
          end
          else
            st_next.cal_cnt = st_reg.cal_cnt + 6'h01;
        end
      end
      default:
        st_next.cal = dadc_pkg::DADC_CAL_IDLE;
    endcase
    // Pipeline freezes outside normal mode so outputs hold the last result
    if (converting)                                                         // [R12] [R15]
    begin
      st_next.s1.i  = dadc_correct(fl_reg.samp.i, st_reg.coef_i);           // [R6]
      st_next.s1.q  = dadc_correct(fl_reg.samp.q, st_reg.coef_q);
      st_next.s2.i  = dadc_format(st_reg.s1.i, st_reg.ctrl.output_coding_select); // [R10]
      st_next.s2.q  = dadc_format(st_reg.s1.q, st_reg.ctrl.output_coding_select);
      st_next.out   = st_reg.s2;                                            // [R18]
    end
    if (!resetn)
    begin
      st_next         = '0;
      st_next.ctrl    = dadc_pkg::dadc_ctrl_type'(`DADC_CTRL_RESET);
      st_next.power   = dadc_pkg::DADC_PWR_NORMAL;
      st_next.cal     = dadc_pkg::DADC_CAL_IDLE;
      st_next.coef_i  = 10'h000;                                            // [R7]
      st_next.coef_q  = 10'h000;
    end
  end

  always_ff @(posedge clk)
  begin
    st_reg <= st_next;
  end

  always_comb
  begin
    fl_next = fl_reg;
    if (converting)
      fl_next.samp = {conv_i_raw, conv_q_raw};                              // [R1]
    fl_next.mux_q = st_reg.out.q;                                           // [R19] [R20]
    if (!resetn)
      fl_next = '0;
  end

  // Sampling and the shared-bus second half run on the falling edge
  always_ff @(negedge clk)
  begin
    fl_reg <= fl_next;
  end

  // Output-DDR style select; both legs come from flip-flops
  assign bus_a_data = (st_reg.ctrl.bus_select || clk) ? st_reg.out.i : fl_reg.mux_q; // [R2] [R20]
  assign bus_b_data = st_reg.ctrl.bus_select ? st_reg.out.q : 10'h000;     // [R2] [R3]
  assign analog_gain_high = st_reg.ctrl.gain_high;                          // [R16]
  assign analog_sleep     = (st_reg.power == dadc_pkg::DADC_PWR_SLEEP);     // [R13]
  assign analog_standby   = (st_reg.power == dadc_pkg::DADC_PWR_STANDBY);   // [R11]
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_reg.rdata;

  property p_mux_b_low;
    @(posedge clk) disable iff (!resetn) !st_reg.ctrl.bus_select |-> bus_b_data == 10'h000;
  endproperty
  a_mux_b_low: assert property (p_mux_b_low) else $error("bus two not low in mux mode"); // [R3]

  property p_par_b;
    @(posedge clk) disable iff (!resetn) st_reg.ctrl.bus_select |-> bus_b_data == st_reg.out.q;
  endproperty
  a_par_b: assert property (p_par_b) else $error("bus two not channel two"); // [R2]

  property p_cal_start;
    @(posedge clk) disable iff (!resetn)
      (trig_rise && st_reg.cal == dadc_pkg::DADC_CAL_IDLE) |=> st_reg.cal == dadc_pkg::DADC_CAL_RUN && st_reg.cal_cnt == 6'h00;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("trigger edge did not start"); // [R4]

  property p_cal_len;
    @(posedge clk) disable iff (!resetn)
      $fell(st_reg.cal == dadc_pkg::DADC_CAL_RUN) |-> $past(st_reg.cal_cnt) == `DADC_CAL_LAST;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("sequence length wrong"); // [R5]

  property p_ignore_edge;
    @(posedge clk) disable iff (!resetn)
      (trig_rise && st_reg.cal == dadc_pkg::DADC_CAL_RUN && converting && st_reg.cal_cnt != `DADC_CAL_LAST)
        |=> st_reg.cal_cnt == $past(st_reg.cal_cnt) + 6'h01;
  endproperty
  a_ignore_edge: assert property (p_ignore_edge) else $error("edge restarted sequence"); // [R21]

  property p_reset_coef;
    @(posedge clk) $past(!resetn) |-> st_reg.coef_i == 10'h000 && st_reg.coef_q == 10'h000;
  endproperty
  a_reset_coef: assert property (p_reset_coef) else $error("coefficient not cleared"); // [R7]

  property p_subtract;
    @(posedge clk) disable iff (!resetn)
      converting |=> st_reg.s1.i == dadc_correct($past(fl_reg.samp.i), $past(st_reg.coef_i));
  endproperty
  a_subtract: assert property (p_subtract) else $error("offset not subtracted"); // [R6]

  property p_format;
    @(posedge clk) disable iff (!resetn)
      (converting && st_reg.ctrl.output_coding_select) |=> st_reg.s2.i == $past(st_reg.s1.i);
  endproperty
  a_format: assert property (p_format) else $error("two's complement coding wrong"); // [R10]

  property p_latency;
    @(posedge clk) disable iff (!resetn)
      (converting && !st_reg.ctrl.output_coding_select) ##1 converting |=> st_reg.out.i == ($past(st_reg.s1.i, 2) ^ 10'h200);
  endproperty
  a_latency: assert property (p_latency) else $error("output latency wrong"); // [R18]

  property p_hold;
    @(posedge clk) disable iff (!resetn) !converting |=> $stable(st_reg.out);
  endproperty
  a_hold: assert property (p_hold) else $error("output changed in low power"); // [R12] [R15]

  property p_priority;
    @(posedge clk) disable iff (!resetn)
      (st_reg.ctrl.sleep_request && st_reg.ctrl.low_power_hold) |=> analog_sleep && !analog_standby;
  endproperty
  a_priority: assert property (p_priority) else $error("sleep lost priority"); // [R14]

  c_cal_done: cover property (@(posedge clk) disable iff (!resetn) $fell(st_reg.cal == dadc_pkg::DADC_CAL_RUN));
  c_mux: cover property (@(posedge clk) disable iff (!resetn) !st_reg.ctrl.bus_select && converting);
  c_sleep: cover property (@(posedge clk) disable iff (!resetn) $rose(analog_sleep));
  c_standby: cover property (@(posedge clk) disable iff (!resetn) $rose(analog_standby));

endmodule

// *** dv/dadc_analog_model.sv ***
`timescale 1ns/1ns
module dadc_analog_model
(
  input  wire logic       clk,
  input  wire logic       standby,
  input  wire logic       sleep,
  input  wire logic [9:0] i_code,
  input  wire logic [9:0] q_code,
  output logic      [9:0] conv_i_raw,
  output logic      [9:0] conv_q_raw
);
  // Codes move on the falling edge, one clock ahead of the edge that samples them
  always_ff @(negedge clk)
  begin
    // A stopped core has no valid code: toggle so a stale capture shows up
    if (standby || sleep)
    begin
      conv_i_raw <= ~conv_i_raw;
      conv_q_raw <= ~conv_q_raw;
    end
    else
    begin
      conv_i_raw <= i_code;
      conv_q_raw <= q_code;
    end
  end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  logic        clk;
  logic        resetn;
  logic        hsel;
  logic        hwrite;
  logic        hready;
  logic        hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [9:0]  i_code;
  logic [9:0]  q_code;
  logic [9:0]  raw_i;
  logic [9:0]  raw_q;
  logic [9:0]  bus_a;
  logic [9:0]  bus_b;
  logic [9:0]  cur_i;
  logic [9:0]  cur_q;
  logic [9:0]  coef_i;
  logic [9:0]  coef_q;
  logic        gain;
  logic        lp_hold;
  logic        slp;
  logic        par;
  logic        fmt;
  int          miscompares;
  int          check_count;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  dadc_ctrl i_dut
  (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .conv_i_raw(raw_i),
    .conv_q_raw(raw_q), .bus_a_data(bus_a), .bus_b_data(bus_b), .analog_gain_high(gain),
    .analog_standby(lp_hold), .analog_sleep(slp)
  );

  dadc_analog_model i_core
  (
    .clk(clk), .standby(lp_hold), .sleep(slp), .i_code(i_code), .q_code(q_code), .conv_i_raw(raw_i),
    .conv_q_raw(raw_q)
  );

  task automatic conclude();
    $display("comparisons %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkb(input string nm, input logic [9:0] e, input logic [9:0] g);
    chk(nm, {22'h0, e}, {22'h0, g});
  endtask

  task automatic wait_rdy();
    for (int n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (hready === 1'b1)
        return;
    end
    miscompares++;
    conclude();
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask

  // Saturating corrected value, then coding; mirrors the output path by hand
  function automatic logic [9:0] ex(input logic [9:0] r, input logic [9:0] c);
    logic signed [11:0] v;
    v = $signed({2'b00, r}) - $signed({{2{c[9]}}, c});
    if (v < 0)
      v = 12'sh000;
    if (v > 12'sh3FF)
      v = 12'sh3FF;
    return v[9:0] ^ (fmt ? 10'h200 : 10'h000);
  endfunction

  // New codes reach the core at the next fall and are sampled one fall later
  task automatic apply(input logic [9:0] ni, input logic [9:0] nq);
    logic [9:0] oi;
    logic [9:0] oq;
    oi = ex(cur_i, coef_i);
    oq = ex(cur_q, coef_q);
    i_code <= ni;
    q_code <= nq;
    cur_i = ni;
    cur_q = nq;
    repeat (3) @(posedge clk);
    #5 chkb("bus_a old", oi, bus_a);
    @(negedge clk);
    #5 chkb("bus_a low old", par ? oi : oq, bus_a);
    @(posedge clk);
    #5 chkb("bus_a", ex(ni, coef_i), bus_a);
    chkb("bus_b", par ? ex(nq, coef_q) : 10'h000, bus_b);
    @(negedge clk);
    #5 chkb("bus_a low", par ? ex(ni, coef_i) : ex(nq, coef_q), bus_a);
    @(posedge clk);
  endtask

  initial
  begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    i_code = 10'h264;
    q_code = 10'h1CE;
    cur_i = 10'h264;
    cur_q = 10'h1CE;
    coef_i = 10'h000;
    coef_q = 10'h000;
    par = 1'b1;
    fmt = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rdchk("ctrl", 32'h0000_0000, 32'h0000_0001);
    rdchk("status", 32'h0000_0004, 32'h0000_0002);
    rdchk("coef", 32'h0000_0008, 32'h0000_0000);
    ahb(1'b1, 32'h0000_0004, 32'hFFFF_FFFF);
    rdchk("status ro", 32'h0000_0004, 32'h0000_0002);
    apply(10'h2A5, 10'h11B);
    rdchk("result", 32'h0000_000C, 32'h011B_02A5);
    ahb(1'b1, 32'h0000_0000, 32'h0000_0012);
    fmt = 1'b1;
    par = 1'b0;
    apply(10'h3F0, 10'h00F);
    chk("gain", 32'h0000_0001, {31'h0, gain});
    ahb(1'b1, 32'h0000_0000, 32'h0000_0013);
    par = 1'b1;
    apply(10'h155, 10'h2AA);
    ahb(1'b1, 32'h0000_0000, 32'h0000_0017);
    i_code <= 10'h3FF;
    q_code <= 10'h000;
    // Power state follows the control write one cycle later
    @(posedge clk);
    rdchk("status", 32'h0000_0004, 32'h0000_0004);
    chk("standby", 32'h0000_0001, {31'h0, lp_hold});
    repeat (10) @(posedge clk);
    #5 chkb("hold a", ex(cur_i, coef_i), bus_a);
    chkb("hold b", ex(cur_q, coef_q), bus_b);
    ahb(1'b1, 32'h0000_0000, 32'h0000_001F);
    @(posedge clk);
    rdchk("status", 32'h0000_0004, 32'h0000_0008);
    chk("sleep", 32'h0000_0001, {31'h0, slp});
    repeat (10) @(posedge clk);
    #5 chkb("sleep a", ex(cur_i, coef_i), bus_a);
    chkb("sleep b", ex(cur_q, coef_q), bus_b);
    ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
    fmt = 1'b0;
    cur_i = 10'h3FF;
    cur_q = 10'h000;
    repeat (10) @(posedge clk);
    chk("awake", 32'h0000_0000, {29'h0, gain, lp_hold, slp});
    apply(10'h205, 10'h1FD);
    ahb(1'b1, 32'h0000_0000, 32'h0000_0021);
    // Trigger edge is seen as soon as the write lands; the sequence starts one cycle later
    @(posedge clk);
    rdchk("busy", 32'h0000_0004, 32'h0000_0003);
    ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
    ahb(1'b1, 32'h0000_0000, 32'h0000_0021);
    repeat (30) @(posedge clk);
    rdchk("done", 32'h0000_0004, 32'h0000_0002);
    rdchk("coef", 32'h0000_0008, 32'h03FD_0005);
    coef_i = 10'h005;
    coef_q = 10'h3FD;
    apply(10'h300, 10'h010);
    apply(10'h002, 10'h3FE);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rdchk("coef", 32'h0000_0008, 32'h0000_0000);
    conclude();
  end
endmodule
